// ### lcd_cfg.svh
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// register indices; the bus byte address is four times the index
`define LCD_RAM_FIRST_IDX 8'h60
`define LCD_RAM_LAST_IDX 8'h71
`define LCD_CTRL_IDX 8'h72

// display memory and pin counts
`define LCD_RAM_DEPTH 18
`define LCD_RAM_LAST_ADDR 5'h11
`define LCD_SEGS 36
`define LCD_COMS 4
`define LCD_PORT_SEG_FIRST 20

// control register value after reset: stopped, blanked
`define LCD_CTRL_RESET 8'h10

// slot length exponents for frame period code 00
`define LCD_MAIN_EXP_BASE 4'hC
`define LCD_SUB_EXP_BASE 4'h5
`define LCD_DIV_W 15

// drive level codes, V0 is ground
`define LCD_LVL_V0 2'h0
`define LCD_LVL_V1 2'h1
`define LCD_LVL_V2 2'h2
`define LCD_LVL_V3 2'h3

`endif

// ### lcd_pkg.sv
`include "lcd_cfg.svh"

package lcd_pkg;

  // display mode, in field order 00..11
  typedef enum logic [1:0] {DUTY_STOP, DUTY_HALF, DUTY_THIRD, DUTY_QUARTER} duty_t;

  // control register layout, bit 7 first
  typedef struct packed {
    logic drive_clock_select;
    logic watch_mode_run;
    logic divider_connect;
    logic blank_display;
    duty_t duty;
    logic [1:0] frame_period;
  } ctrl_t;

  typedef logic [1:0] level_t;

  // backplane and frontplane levels travel together
  typedef struct packed {
    level_t [`LCD_COMS-1:0] backplane_drive;
    level_t [`LCD_SEGS-1:0] frontplane_drive;
  } drive_t;

  // index of the last common phase for a duty
  function automatic logic [1:0] last_phase(input duty_t d);
    unique case (d)
      DUTY_STOP: last_phase = 2'h0;
      DUTY_HALF: last_phase = 2'h1;
      DUTY_THIRD: last_phase = 2'h2;
      DUTY_QUARTER: last_phase = 2'h3;
    endcase
  endfunction : last_phase

  // low-bit mask of the slot divider for an exponent
  function automatic logic [`LCD_DIV_W-1:0] slot_mask(input logic [3:0] e);
    logic [15:0] one_hot;
    one_hot = 16'h0001 << e;
    slot_mask = 15'(one_hot - 16'h0001);
  endfunction : slot_mask

endpackage : lcd_pkg

// ### display_ram.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcd_cfg.svh"

module display_ram (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] bus_raddr,
  output logic [7:0] bus_rdata,
  input wire logic [4:0] scan_raddr,
  output logic [7:0] scan_rdata
);
  import lcd_pkg::*;

  typedef struct packed {
    logic [`LCD_RAM_DEPTH-1:0][7:0] mem;
    logic [7:0] bus_rdata;
    logic [7:0] scan_rdata;
  } ram_state_t;

  ram_state_t st_reg, st_next;

  // write-first on both ports so a read right behind a write sees the new byte
  always_comb begin
    st_next = st_reg;
    if (we && waddr <= `LCD_RAM_LAST_ADDR) begin
      st_next.mem[waddr] = wdata;
    end
    st_next.bus_rdata = (bus_raddr <= `LCD_RAM_LAST_ADDR) ? st_next.mem[bus_raddr] : 8'h00;
    st_next.scan_rdata = (scan_raddr <= `LCD_RAM_LAST_ADDR) ? st_next.mem[scan_raddr] : 8'h00;
  end

  // cleared at reset so the first scans show a blank panel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.bus_rdata;
  assign scan_rdata = st_reg.scan_rdata;

endmodule : display_ram

`default_nettype wire

// ### frame_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcd_cfg.svh"

module frame_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic run,
  input wire logic [3:0] period_exp,
  output logic slot_end
);
  import lcd_pkg::*;

  typedef struct packed {
    logic [`LCD_DIV_W-1:0] div_cnt;
  } timer_state_t;

  timer_state_t st_reg, st_next;
  logic [`LCD_DIV_W-1:0] mask;

  // a slot lasts 2**period_exp ticks; masking tolerates a shorter period set mid-slot
  always_comb begin
    st_next = st_reg;
    mask = slot_mask(period_exp);
    slot_end = run && tick && ((st_reg.div_cnt & mask) == mask);
    if (!run || slot_end) begin
      st_next.div_cnt = '0;
    end else if (tick) begin
      st_next.div_cnt = st_reg.div_cnt + 15'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : frame_timer

`default_nettype wire

// ### lcd_segment_common_driver.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcd_cfg.svh"

module lcd_segment_common_driver #(
  parameter bit HIGH_SEGS_AS_PORT = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sub_clk_pin,
  input wire logic watch_mode,
  output lcd_pkg::drive_t lcd_drive,
  output logic divider_connect,
  output logic divider_enable
);
  import lcd_pkg::*;

  typedef struct packed {
    ctrl_t ctrl_reg;
    logic [1:0] phase;
    logic ac_frame;
    logic [4:0] scan_idx;
    logic [4:0] scan_prev;
    logic [`LCD_SEGS-1:0] seg_bits;
    drive_t drive;
    logic [1:0] sub_sync;
    logic sub_prev;
    logic wr_ram;
    logic wr_ctrl;
    logic rd_ram;
    logic rd_ctrl;
    logic [4:0] dp_addr;
    logic [7:0] ctrl_rd;
    logic div_en;
  } main_state_t;

  main_state_t st_reg, st_next;

  logic [7:0] idx;
  logic addr_ok;
  logic hit_ram;
  logic hit_ctrl;
  logic accept;
  logic [4:0] ram_raddr;
  logic [7:0] bus_rdata;
  logic [7:0] scan_rdata;
  logic running;
  logic tick;
  logic sub_rise;
  logic [3:0] period_exp;
  logic slot_end;
  level_t com_sel;
  level_t com_unsel;
  level_t seg_lit;
  level_t seg_unlit;

  // address phase decode: word transfers only, anything else is ignored
  assign idx = haddr[9:2];
  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign hit_ram = addr_ok && (idx >= `LCD_RAM_FIRST_IDX) && (idx <= `LCD_RAM_LAST_IDX);
  assign hit_ctrl = addr_ok && (idx == `LCD_CTRL_IDX);
  assign accept = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign ram_raddr = 5'(idx - `LCD_RAM_FIRST_IDX);

  // the display stops when mode is stop or in watch mode without the run bit
  assign running = (st_reg.ctrl_reg.duty != DUTY_STOP) &&
                   !(watch_mode && !st_reg.ctrl_reg.watch_mode_run);

  // the subclock pin is sampled through two flops; only the second one is edge-detected
  assign sub_rise = st_reg.sub_sync[1] && !st_reg.sub_prev;
  assign tick = st_reg.ctrl_reg.drive_clock_select ? sub_rise : 1'b1;
  assign period_exp = st_reg.ctrl_reg.drive_clock_select ?
                      (`LCD_SUB_EXP_BASE + {2'h0, st_reg.ctrl_reg.frame_period}) :
                      (`LCD_MAIN_EXP_BASE + {2'h0, st_reg.ctrl_reg.frame_period});

  // two-frame ac pattern: frame b swaps the outer and the inner levels
  assign com_sel = st_reg.ac_frame ? `LCD_LVL_V0 : `LCD_LVL_V3;
  assign com_unsel = st_reg.ac_frame ? `LCD_LVL_V2 : `LCD_LVL_V1;
  assign seg_lit = st_reg.ac_frame ? `LCD_LVL_V3 : `LCD_LVL_V0;
  assign seg_unlit = st_reg.ac_frame ? `LCD_LVL_V1 : `LCD_LVL_V2;

  frame_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .run(running),
    .period_exp(period_exp),
    .slot_end(slot_end)
  );

  display_ram u_ram (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(st_reg.wr_ram),
    .waddr(st_reg.dp_addr),
    .wdata(hwdata[7:0]),
    .bus_raddr(ram_raddr),
    .bus_rdata(bus_rdata),
    .scan_raddr(st_reg.scan_idx),
    .scan_rdata(scan_rdata)
  );

  // next-state logic for bus, scan, phase sequencing and pin levels
  always_comb begin
    st_next = st_reg;
    st_next.sub_sync = {st_reg.sub_sync[0], sub_clk_pin};
    st_next.sub_prev = st_reg.sub_sync[1];

    // bus: capture address phase, finish writes in the data phase
    st_next.wr_ram = accept && hwrite && hit_ram;
    st_next.wr_ctrl = accept && hwrite && hit_ctrl;
    st_next.rd_ram = accept && !hwrite && hit_ram;
    st_next.rd_ctrl = accept && !hwrite && hit_ctrl;
    if (accept) begin
      st_next.dp_addr = ram_raddr;
    end
    if (st_reg.wr_ctrl) begin
      st_next.ctrl_reg = ctrl_t'(hwdata[7:0]);
    end
    // forward a control write that completes in the same edge as the read
    st_next.ctrl_rd = st_reg.wr_ctrl ? hwdata[7:0] : st_reg.ctrl_reg;

    // scan walks the memory on its own port, one byte a cycle, never waiting on the bus
    st_next.scan_idx = (st_reg.scan_idx == `LCD_RAM_LAST_ADDR) ? 5'h00 : st_reg.scan_idx + 5'h01;
    st_next.scan_prev = st_reg.scan_idx;
    st_next.seg_bits[{st_reg.scan_prev, 1'b0}] = scan_rdata[{1'b0, st_reg.phase}];
    st_next.seg_bits[{st_reg.scan_prev, 1'b1}] = scan_rdata[{1'b1, st_reg.phase}];

    // equal slots, wrap after the last phase of the duty and flip frame polarity
    if (!running) begin
      st_next.phase = 2'h0;
      st_next.ac_frame = 1'b0;
    end else if (slot_end) begin
      if (st_reg.phase >= last_phase(st_reg.ctrl_reg.duty)) begin
        st_next.phase = 2'h0;
        st_next.ac_frame = !st_reg.ac_frame;
      end else begin
        st_next.phase = st_reg.phase + 2'h1;
      end
    end

    // commons past the duty stay unselected, a waveform the panel does not use
    for (int c = 0; c < `LCD_COMS; c++) begin
      if (!running) begin
        st_next.drive.backplane_drive[c] = `LCD_LVL_V0;
      end else if (c == int'(st_reg.phase)) begin
        st_next.drive.backplane_drive[c] = com_sel;
      end else begin
        st_next.drive.backplane_drive[c] = com_unsel;
      end
    end

    // segments: lit on a set bit unless blanked; port-optioned segments get ground
    for (int s = 0; s < `LCD_SEGS; s++) begin
      if (!running || (HIGH_SEGS_AS_PORT && s >= `LCD_PORT_SEG_FIRST)) begin
        st_next.drive.frontplane_drive[s] = `LCD_LVL_V0;
      end else if (st_reg.seg_bits[s] && !st_reg.ctrl_reg.blank_display) begin
        st_next.drive.frontplane_drive[s] = seg_lit;
      end else begin
        st_next.drive.frontplane_drive[s] = seg_unlit;
      end
    end

    st_next.div_en = running;
  end

  // control, scan and pin state held here; reset leaves every pin at ground
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.ctrl_reg <= ctrl_t'(`LCD_CTRL_RESET);
    end else begin
      st_reg <= st_next;
    end
  end

  // zero wait states, always okay; unmapped reads return zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rd_ram ? {24'h000000, bus_rdata} :
                  st_reg.rd_ctrl ? {24'h000000, st_reg.ctrl_rd} : 32'h00000000;
  assign lcd_drive = st_reg.drive;
  assign divider_connect = st_reg.ctrl_reg.divider_connect;
  assign divider_enable = st_reg.div_en;

  // helper for assertions: ticks counted since the last slot end, valid while settings hold
  logic [15:0] tick_gap;
  logic gap_ok;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_gap <= 16'h0000;
      gap_ok <= 1'b0;
    end else begin
      if (slot_end) begin
        tick_gap <= 16'h0000;
      end else if (tick && running) begin
        tick_gap <= tick_gap + 16'h0001;
      end
      if (!running || st_reg.wr_ctrl) begin
        gap_ok <= 1'b0;
      end else if (slot_end) begin
        gap_ok <= 1'b1;
      end
    end
  end

  a_main_slot_len: assert property (
    @(posedge hclk) disable iff (!hresetn)
    slot_end && gap_ok && !st_reg.ctrl_reg.drive_clock_select |->
      tick_gap == {1'b0, slot_mask(`LCD_MAIN_EXP_BASE + {2'h0, st_reg.ctrl_reg.frame_period})})
    else $error("main clock slot length wrong");

  a_sub_slot_len: assert property (
    @(posedge hclk) disable iff (!hresetn)
    slot_end && gap_ok && st_reg.ctrl_reg.drive_clock_select |->
      tick_gap == {1'b0, slot_mask(`LCD_SUB_EXP_BASE + {2'h0, st_reg.ctrl_reg.frame_period})})
    else $error("subclock slot length wrong");

  a_phase_in_duty: assert property (
    @(posedge hclk) disable iff (!hresetn)
    running && $stable(st_reg.ctrl_reg) && slot_end |=> st_reg.phase <= last_phase(st_reg.ctrl_reg.duty))
    else $error("phase beyond duty");

  a_frame_flip: assert property (
    @(posedge hclk) disable iff (!hresetn)
    running && slot_end && st_reg.phase == last_phase(st_reg.ctrl_reg.duty) && !st_reg.wr_ctrl |=>
      st_reg.phase == 2'h0 && st_reg.ac_frame != $past(st_reg.ac_frame))
    else $error("frame polarity did not flip at wrap");

  a_stop_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !running |=> st_reg.drive == '0 && !divider_enable)
    else $error("outputs not low while stopped");

  a_watch_stop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    watch_mode && !st_reg.ctrl_reg.watch_mode_run |=> !divider_enable && st_reg.drive == '0)
    else $error("display kept running in watch mode");

  a_one_com_sel: assert property (
    @(posedge hclk) disable iff (!hresetn)
    running && $stable(st_reg.phase) && $stable(st_reg.ac_frame) && $past(running) |=>
      lcd_drive.backplane_drive[$past(st_reg.phase)] == ($past(st_reg.ac_frame) ? `LCD_LVL_V0 : `LCD_LVL_V3))
    else $error("active common not at selected level");

  a_blank_unlit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    running && st_reg.ctrl_reg.blank_display |=>
      lcd_drive.frontplane_drive[0] == ($past(st_reg.ac_frame) ? `LCD_LVL_V1 : `LCD_LVL_V2))
    else $error("segment lit while blanked");

  a_ctrl_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_reg.wr_ctrl |=> divider_connect == $past(hwdata[5]) ##1 st_reg.ctrl_reg.divider_connect == $past(hwdata[5], 2))
    else $error("divider connect not taken from write");

  c_quarter_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
    st_reg.ctrl_reg.duty == DUTY_QUARTER && slot_end && st_reg.phase == 2'h3);
  c_sub_slot: cover property (@(posedge hclk) disable iff (!hresetn)
    st_reg.ctrl_reg.drive_clock_select && slot_end);
  c_blank_run: cover property (@(posedge hclk) disable iff (!hresetn)
    running && st_reg.ctrl_reg.blank_display);
  c_ram_read: cover property (@(posedge hclk) disable iff (!hresetn)
    st_reg.rd_ram && bus_rdata != 8'h00);

endmodule : lcd_segment_common_driver

`default_nettype wire

// ### lcd_glass_model.sv
`timescale 1ns/100ps
`default_nettype none

// passive glass: a cell lights only when full bias sits across it
module lcd_glass_model (
  input wire lcd_pkg::drive_t lcd_drive,
  output logic [3:0][35:0] pixel_on
);
  import lcd_pkg::*;

  // either frame polarity counts, so the ac inversion must keep lit cells lit
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 36; s++) begin
        pixel_on[c][s] = (lcd_drive.backplane_drive[c] == 2'h3 && lcd_drive.frontplane_drive[s] == 2'h0) ||
                         (lcd_drive.backplane_drive[c] == 2'h0 && lcd_drive.frontplane_drive[s] == 2'h3);
      end
    end
  end
endmodule : lcd_glass_model

`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcd_cfg.svh"

module testbench;
  import lcd_pkg::*;

  localparam logic [31:0] ctrl_a = 32'(`LCD_CTRL_IDX) << 2;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sub_clk_pin, watch_mode;
  logic divider_connect, divider_enable, blank;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] b0, b17;
  drive_t lcd_drive;
  logic [3:0][35:0] pixel_on;
  int err_total, n_tests, cyc;

  lcd_segment_common_driver dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sub_clk_pin(sub_clk_pin), .watch_mode(watch_mode), .lcd_drive(lcd_drive),
    .divider_connect(divider_connect), .divider_enable(divider_enable)
  );
  lcd_glass_model glass_u (.lcd_drive(lcd_drive), .pixel_on(pixel_on));

  always #2.5 hclk = ~hclk;
  // subclock sped up so slots stay short; its edges fall on hclk falling edges, never on rising ones
  always #20 sub_clk_pin = ~sub_clk_pin;

  // cycle count doubles as the hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [31:0] ram_a(input int k);
    return (32'(`LCD_RAM_FIRST_IDX) + 32'(k)) << 2;
  endfunction : ram_a

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_val

  task automatic cmp_lvl(input level_t g, input level_t e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_lvl

  // one single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d, input logic [2:0] sz,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    cmp_val({30'h0, hresp, hreadyout}, 32'h1);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 3'h2, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, sz, r);
    cmp_val(r, e);
  endtask : rd_chk

  task automatic wait_until(input int t);
    while (cyc < t) @(posedge hclk);
  endtask : wait_until

  // commons plus the first and last segment pairs, mid-slot of phase p
  task automatic check_phase(input int p, input bit fa);
    logic [7:0] v;
    logic lit;
    int s;
    for (int i = 0; i < 4; i++) begin
      cmp_lvl(lcd_drive.backplane_drive[i], i == p ? (fa ? `LCD_LVL_V3 : `LCD_LVL_V0) : (fa ? `LCD_LVL_V1 : `LCD_LVL_V2));
    end
    for (int j = 0; j < 4; j++) begin
      s = j < 2 ? j : 32 + j;
      v = j < 2 ? b0 : b17;
      lit = v[p + 4 * (j % 2)] & ~blank;
      cmp_lvl(lcd_drive.frontplane_drive[s], lit ? (fa ? `LCD_LVL_V0 : `LCD_LVL_V3) : (fa ? `LCD_LVL_V2 : `LCD_LVL_V1));
      cmp_val(32'(pixel_on[p][s]), 32'(lit));
    end
  endtask : check_phase

  // start from stop, follow two frames, then stop again
  task automatic run(input logic [7:0] ctrl, input int n, input int slot);
    logic prev;
    int t0;
    blank = ctrl[4];
    wr(ctrl_a, ctrl);
    t0 = cyc;
    do begin
      prev = lcd_drive.backplane_drive[0] === `LCD_LVL_V3;
      @(posedge hclk);
    end while (!(lcd_drive.backplane_drive[0] === `LCD_LVL_V3 && !prev) && cyc < t0 + 100);
    cmp_val(32'(cyc < t0 + 8), 32'h1);
    t0 = cyc;
    wr(ram_a(17), b17);
    wait_until(t0 + slot / 2);
    check_phase(0, 1'b1);
    cmp_val(32'(divider_enable), 32'h1);
    cmp_val(32'(divider_connect), 32'(ctrl[5]));
    // the first slot is cut short by where the subclock stands at start, so the second one is timed
    while (lcd_drive.backplane_drive[1] !== `LCD_LVL_V3 && cyc < t0 + 2 * slot) @(posedge hclk);
    t0 = cyc;
    for (int k = 1; k < 2 * n; k++) begin
      wait_until(t0 + slot / 2 + (k - 1) * slot);
      check_phase(k % n, k < n);
      if (k == 1) begin
        while (lcd_drive.backplane_drive[1] === `LCD_LVL_V3 && cyc < t0 + 2 * slot) @(posedge hclk);
        cmp_val(32'(cyc - t0), 32'(slot));
      end
    end
    wr(ctrl_a, ctrl & 8'hF3);
    repeat (2) @(posedge hclk);
    cmp_val(32'(|lcd_drive), 32'h0);
    cmp_val(32'(divider_enable), 32'h0);
  endtask : run

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sub_clk_pin = 1'b0;
    watch_mode = 1'b0;
    blank = 1'b0;
    b0 = 8'h96;
    b17 = 8'h69;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(posedge hclk);
    cmp_val(32'(|lcd_drive), 32'h0);
    cmp_val({30'h0, divider_enable, divider_connect}, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(ctrl_a, 3'h2, 32'h10);
    rd_chk(ram_a(0), 3'h2, 32'h0);
    wr(ram_a(0), b0);
    rd_chk(ram_a(0), 3'h2, {24'h0, b0});
    rd_chk(ctrl_a + 32'h4, 3'h2, 32'h0);
    rd_chk(ctrl_a, 3'h0, 32'h0);
    run(8'h2C, 4, 4096);
    // blank first so the source change cannot flicker
    wr(ctrl_a, 8'h30);
    wr(ctrl_a, 8'hB0);
    run(8'h85, 2, 512);
    run(8'h9A, 3, 1024);
    // watch mode without the run bit stops the glass, with it the glass keeps going
    wr(ctrl_a, 8'h85);
    repeat (4) @(posedge hclk);
    watch_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp_val(32'(|lcd_drive), 32'h0);
    cmp_val(32'(divider_enable), 32'h0);
    wr(ctrl_a, 8'hC5);
    repeat (3) @(posedge hclk);
    cmp_val(32'(divider_enable), 32'h1);
    cmp_val(32'(|lcd_drive), 32'h1);
    watch_mode <= 1'b0;
    test_done();
  end
endmodule : testbench

`default_nettype wire
